// [rtl/lsf_ctrl.sv]
/*
 * LED sink fault and adaptive boost controller with AXI4-Lite registers.
 * Assumes all analog comparator and enable inputs are synchronous to aclk;
 * the fault pin is open drain, pulled low while fault_oe is high.
 */
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// ==============================================================
// Persistence filter: output follows input held for limit cycles
module lsf_filt #(
	parameter int CW = 9
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          raw,
	input  wire logic [CW-1:0] limit,
	output logic               filt
);
	logic [CW-1:0] cnt_ff;
	logic          filt_ff;

	// Disagreement must last limit cycles before the output moves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= '0;
			filt_ff <= 1'b0;
		end else if (raw == filt_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= limit - 1'b1) begin
			cnt_ff  <= '0;
			filt_ff <= raw;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
	assign filt = filt_ff;
endmodule

// ==============================================================
// Operation
// - Grounded sinks found at start-up stay excluded
// - Enabled sinks follow PWM input directly
// - Boost target is 8-bit code, 256 steps
// - Periodic downward nudge of boost target
// - Nine comparator results filtered for 1 us
// - All sinks inside window: target unchanged
// - All sinks above ceiling: step target down
// - Any sink below floor: step target up
// - Floor miss at max target flags open
// - Above short level, other in window: short
// - String fault disables sink only, fault low
// - 2-20 us enable low clears string faults
// - Longer enable low enters standby, restarts
// - Other faults enter recovery, all off
// - Recovery returns active after 100 ms
// - Input overvoltage needs 100 us persistence
// - Output overvoltage 560/50 ms filter, 160 ms
// - Undervoltage sensed always, 100 us persistence
// - Overtemperature held until indication clears
// - Standby waits enable, then senses outputs
module lsf_ctrl import lsf_pkg::*; #(
	parameter int NSINK     = 3,
	parameter int CLR_MAX   = CLR_MAX_CYC,
	parameter int PERSIST   = PERSIST_CYC,
	parameter int RECOV     = RECOV_CYC,
	parameter int OVP_LONG  = OVP_LONG_CYC,
	parameter int OVP_SHORT = OVP_SHORT_CYC,
	parameter int OVP_REARM = OVP_REARM_CYC
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             supply_enable_pin,
	input  wire logic             pwm_in,
	input  wire logic [NSINK-1:0] sink_grounded,
	input  wire logic [NSINK-1:0] cmp_floor_below,
	input  wire logic [NSINK-1:0] cmp_ceiling_above,
	input  wire logic [NSINK-1:0] cmp_short_above,
	input  wire logic             vin_over_raw,
	input  wire logic             vin_under_raw,
	input  wire logic             vout_over_raw,
	input  wire logic             die_hot,
	output logic [NSINK-1:0]      sink_en,
	output logic                  boost_en,
	output logic [CODE_W-1:0]     boost_target,
	output logic                  fault_o,
	output logic                  fault_oe
);
	// ==========================================================
	// Registers
	lsf_state_t        state_ff, nxt_state;
	logic [31:0]       phase_cnt_ff, en_low_cnt_ff, act_time_ff;
	logic [15:0]       tick_cnt_ff, down_cnt_ff, adapt_ff, down_ff;
	logic [CODE_W-1:0] target_ff, nxt_target;
	logic [NSINK-1:0]  gnd_ff, open_ff, short_ff, sink_en_ff;
	logic              en_q_ff, ovp_first_ff, fault_oe_ff;

	// ==========================================================
	// Comparator and protection filters
	logic [3*NSINK-1:0] cmp_raw, cmp_f;
	logic [NSINK-1:0]   lo_f, mid_f, hi_f;
	logic               iov_f, iuv_f, oov_f, monitored;
	logic               input_overvoltage_fault, input_undervoltage_fault;
	logic               boost_overvoltage_fault, die_overtemperature_fault;
	logic [31:0]        oov_limit;

	assign cmp_raw = {cmp_short_above, cmp_ceiling_above, cmp_floor_below};
	assign lo_f    = cmp_f[NSINK-1:0];
	assign mid_f   = cmp_f[2*NSINK-1:NSINK];
	assign hi_f    = cmp_f[3*NSINK-1:2*NSINK];

	genvar gi;
	generate
		for (gi = 0; gi < 3 * NSINK; gi++) begin : g_cmp
			lsf_filt #(.CW(9)) u_cmp (
				.aclk   (aclk),
				.aresetn(aresetn),
				.raw    (cmp_raw[gi]),
				.limit  (9'(CMP_FILT_CYC)),
				.filt   (cmp_f[gi])
			);
		end
	endgenerate

	// Input overvoltage and temperature watched from soft start onward
	assign monitored = (state_ff == ST_SENSE) || (state_ff == ST_ACTIVE);
	// Short filter only after a first trip, to cut repeated stress
	assign oov_limit = ovp_first_ff ? 32'(OVP_SHORT) : 32'(OVP_LONG);

	lsf_filt #(.CW(32)) u_iov (
		.aclk   (aclk),
		.aresetn(aresetn),
		.raw    (vin_over_raw && monitored),
		.limit  (32'(PERSIST)),
		.filt   (iov_f)
	);
	lsf_filt #(.CW(32)) u_iuv (
		.aclk   (aclk),
		.aresetn(aresetn),
		.raw    (vin_under_raw),
		.limit  (32'(PERSIST)),
		.filt   (iuv_f)
	);
	lsf_filt #(.CW(32)) u_oov (
		.aclk   (aclk),
		.aresetn(aresetn),
		.raw    (vout_over_raw && (state_ff == ST_ACTIVE)),
		.limit  (oov_limit),
		.filt   (oov_f)
	);

	assign input_overvoltage_fault   = iov_f && monitored;
	assign input_undervoltage_fault  = iuv_f;
	assign boost_overvoltage_fault   = oov_f && (state_ff == ST_ACTIVE);
	assign die_overtemperature_fault = die_hot && monitored;

	// ==========================================================
	// Enable pin pulse measurement
	logic en_rise, clr_pulse, en_long, sys_fault, fault_now, recov_done;

	assign en_rise   = supply_enable_pin && !en_q_ff;
	assign clr_pulse = en_rise && (state_ff == ST_ACTIVE) &&
		(en_low_cnt_ff >= 32'(CLR_MIN_CYC)) &&
		(en_low_cnt_ff <= 32'(CLR_MAX));
	assign en_long   = !supply_enable_pin &&
		(en_low_cnt_ff >= 32'(CLR_MAX));
	assign sys_fault = input_overvoltage_fault || input_undervoltage_fault ||
		boost_overvoltage_fault || die_overtemperature_fault;
	// Raw levels plus filtered undervoltage decide recovery; filters would hide a fresh glitch
	assign fault_now = vin_over_raw || vin_under_raw || iuv_f || die_hot;
	assign recov_done = phase_cnt_ff >= 32'(RECOV - 1);

	// Low-time counter saturates at the upper end of the clearing window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q_ff       <= 1'b0;
			en_low_cnt_ff <= '0;
		end else begin
			en_q_ff <= supply_enable_pin;
			if (supply_enable_pin)
				en_low_cnt_ff <= '0;
			else if (en_low_cnt_ff < 32'(CLR_MAX))
				en_low_cnt_ff <= en_low_cnt_ff + 32'h1;
		end
	end

	// ==========================================================
	// Device state machine
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_STANDBY: begin
				if (supply_enable_pin && !iuv_f)
					nxt_state = ST_SENSE;
			end
			ST_SENSE: begin
				if (en_long)
					nxt_state = ST_STANDBY;
				else if (sys_fault)
					nxt_state = ST_RECOVERY;
				else if (phase_cnt_ff >= 32'(SENSE_CYC - 1))
					nxt_state = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (en_long)
					nxt_state = ST_STANDBY;
				else if (sys_fault)
					nxt_state = ST_RECOVERY;
			end
			ST_RECOVERY: begin
				if (en_long)
					nxt_state = ST_STANDBY;
				else if (recov_done && !fault_now)
					nxt_state = ST_ACTIVE;
			end
		endcase
	end

	// Phase counter restarts on every state change and recovery retry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff     <= ST_STANDBY;
			phase_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff || (state_ff == ST_RECOVERY && recov_done))
				phase_cnt_ff <= '0;
			else
				phase_cnt_ff <= phase_cnt_ff + 32'h1;
		end
	end

	// Output-overvoltage filter shortening and rearm after active time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovp_first_ff <= 1'b0;
			act_time_ff  <= '0;
		end else begin
			act_time_ff <= (state_ff == ST_ACTIVE && act_time_ff < 32'(OVP_REARM))
				? act_time_ff + 32'h1
				: ((state_ff == ST_ACTIVE) ? act_time_ff : 32'h0);
			if (boost_overvoltage_fault)
				ovp_first_ff <= 1'b1;
			else if (act_time_ff >= 32'(OVP_REARM - 1))
				ovp_first_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Sink bookkeeping and string faults
	logic [NSINK-1:0] act, win, open_set, short_set;
	logic             tick, low_any, all_mid, nudge;

	assign act      = ~gnd_ff & ~open_ff & ~short_ff;
	assign win      = ~lo_f & ~mid_f;
	assign tick     = (state_ff == ST_ACTIVE) && (tick_cnt_ff >= adapt_ff);
	assign low_any  = |(lo_f & act);
	assign all_mid  = (act != '0) && ((mid_f & act) == act);
	assign nudge    = down_cnt_ff >= down_ff;
	assign open_set = (tick && target_ff == TGT_MAX) ? (lo_f & act)
		: '0;
	// Needs a healthy reference string to tell a short from high supply
	assign short_set = (state_ff == ST_ACTIVE && |(win & act))
		? (hi_f & act) : '0;

	// Grounded outputs latched at the end of sensing; hardware set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gnd_ff   <= '0;
			open_ff  <= '0;
			short_ff <= '0;
		end else begin
			if (state_ff == ST_SENSE && nxt_state == ST_ACTIVE)
				gnd_ff <= sink_grounded;
			else if (state_ff == ST_STANDBY)
				gnd_ff <= '0;
			if (state_ff == ST_STANDBY) begin
				open_ff  <= '0;
				short_ff <= '0;
			end else begin
				open_ff  <= (clr_pulse ? '0 : open_ff) | open_set;
				short_ff <= (clr_pulse ? '0 : short_ff) | short_set;
			end
		end
	end

	// ==========================================================
	// Adaptive boost target
	always_comb begin
		nxt_target = target_ff;
		if (state_ff == ST_STANDBY)
			nxt_target = TGT_INIT;
		else if (tick && low_any) begin
			if (target_ff != TGT_MAX)
				nxt_target = target_ff + 8'h01;
		end else if (tick && (all_mid || nudge)) begin
			if (target_ff != TGT_MIN)
				nxt_target = target_ff - 8'h01;
		end
	end

	// Step pacing; the down-pressure count runs on adaptation ticks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			target_ff   <= TGT_INIT;
			tick_cnt_ff <= '0;
			down_cnt_ff <= '0;
		end else begin
			target_ff   <= nxt_target;
			tick_cnt_ff <= tick || state_ff != ST_ACTIVE ? 16'h0
				: tick_cnt_ff + 16'h1;
			if (state_ff != ST_ACTIVE || (tick && (low_any || nudge)))
				down_cnt_ff <= '0;
			else if (tick)
				down_cnt_ff <= down_cnt_ff + 16'h1;
		end
	end

	// ==========================================================
	// Outputs; enable low blanks LEDs without leaving active mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sink_en_ff  <= '0;
			fault_oe_ff <= 1'b0;
		end else begin
			sink_en_ff  <= (state_ff == ST_ACTIVE && supply_enable_pin)
				? (act & {NSINK{pwm_in}}) : '0;
			fault_oe_ff <= (nxt_state == ST_RECOVERY) ||
				(|(open_ff | open_set)) || (|(short_ff | short_set));
		end
	end
	assign sink_en      = sink_en_ff;
	assign boost_en     = monitored;
	assign boost_target = target_ff;
	assign fault_o      = 1'b0;
	assign fault_oe     = fault_oe_ff;

	// ==========================================================
	// AXI4-Lite slave
	logic        aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff, status_w;
	logic [3:0]  wstrb_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        do_write, wr_adapt, wr_down, rd_ok, ar_hs;

	assign s_axi_awready = !aw_full_ff;
	assign s_axi_wready  = !w_full_ff;
	assign s_axi_arready = !rvalid_ff;
	assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
	assign wr_adapt = do_write && awaddr_ff == REG_ADAPT;
	assign wr_down  = do_write && awaddr_ff == REG_DOWN;
	assign ar_hs    = s_axi_arvalid && !rvalid_ff;
	assign rd_ok    = s_axi_araddr == REG_ADAPT || s_axi_araddr == REG_DOWN ||
		s_axi_araddr == REG_STATUS || s_axi_araddr == REG_TARGET;
	assign status_w = 32'({fault_oe_ff, gnd_ff, short_ff, open_ff,
		state_ff});

	// Address and data may arrive in either order; both held till used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
			bresp_ff   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_ff) begin
				aw_full_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_ff) begin
				w_full_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_ff <= 1'b0;
				w_full_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= (wr_adapt || wr_down) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Writable pacing registers, byte lanes 0 and 1 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adapt_ff <= ADAPT_RST;
			down_ff  <= DOWN_RST;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (wr_adapt && wstrb_ff[b])
					adapt_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
				if (wr_down && wstrb_ff[b])
					down_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
			end
		end
	end

	// Read data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				REG_ADAPT:  rdata_ff <= {16'h0000, adapt_ff};
				REG_DOWN:   rdata_ff <= {16'h0000, down_ff};
				REG_STATUS: rdata_ff <= status_w;
				REG_TARGET: rdata_ff <= {24'h000000, target_ff};
				default:    rdata_ff <= 32'h00000000;
			endcase
		end else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_blank;
		state_ff == ST_ACTIVE && !supply_enable_pin;
	endsequence
	sequence s_recov_entry;
		state_ff != ST_RECOVERY ##1 state_ff == ST_RECOVERY;
	endsequence

	AST_GND_OFF: assert property ((gnd_ff & sink_en_ff) == '0)
		else $error("grounded sink driven");
	AST_PWM_FOLLOW: assert property (state_ff == ST_ACTIVE &&
		supply_enable_pin && act[0] |=> sink_en_ff[0] == $past(pwm_in))
		else $error("sink does not follow pwm");
	AST_BLANK: assert property (s_blank |=> sink_en_ff == '0)
		else $error("leds not blanked during enable low");
	AST_UP: assert property (tick && low_any && target_ff != TGT_MAX
		|=> target_ff == $past(target_ff) + 8'h01)
		else $error("target did not step up");
	AST_DOWN: assert property (tick && !low_any && all_mid &&
		target_ff != TGT_MIN |=> target_ff == $past(target_ff) - 8'h01)
		else $error("target did not step down");
	AST_HOLD: assert property (state_ff == ST_ACTIVE && !(tick && (low_any
		|| all_mid || nudge)) |=> $stable(target_ff))
		else $error("target moved without cause");
	// A system fault in the same cycle may take the device to recovery
	AST_OPEN: assert property (|open_set && !sys_fault |=>
		(open_ff & $past(open_set)) == $past(open_set) && fault_oe_ff &&
		state_ff != ST_RECOVERY)
		else $error("open string not latched");
	AST_RECOV_OFF: assert property (s_recov_entry |-> !boost_en
		##1 sink_en_ff == '0 && fault_oe_ff)
		else $error("recovery did not shut outputs");
	AST_STANDBY: assert property (en_long && state_ff != ST_STANDBY
		|=> state_ff == ST_STANDBY)
		else $error("long enable low missed standby");
	AST_RETRY: assert property (state_ff == ST_RECOVERY && recov_done &&
		fault_now && !en_long |=> state_ff == ST_RECOVERY &&
		phase_cnt_ff == 32'h0)
		else $error("recovery did not restart");
endmodule

`default_nettype wire

// [rtl/lsf_pkg.sv]
/*
 * Shared constants of the LED sink fault and adaptive boost controller:
 * timing counts, register map, field positions and the state type.
 * Assumes a 250 MHz system clock; all counts derive from it.
 */
package lsf_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ        = 250;
	localparam int T_CMP_FILT_NS  = 1000;
	localparam int CMP_FILT_CYC   = (T_CMP_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int T_CLR_MIN_NS   = 2000;
	localparam int CLR_MIN_CYC    = (T_CLR_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int T_CLR_MAX_NS   = 20000;
	localparam int CLR_MAX_CYC    = (T_CLR_MAX_NS * CLK_MHZ) / 1000;
	localparam int T_PERSIST_US   = 100;
	localparam int PERSIST_CYC    = T_PERSIST_US * CLK_MHZ;
	localparam int T_RECOV_MS     = 100;
	localparam int RECOV_CYC      = T_RECOV_MS * CLK_MHZ * 1000;
	localparam int T_OVP_LONG_MS  = 560;
	localparam int OVP_LONG_CYC   = T_OVP_LONG_MS * CLK_MHZ * 1000;
	localparam int T_OVP_SHORT_MS = 50;
	localparam int OVP_SHORT_CYC  = T_OVP_SHORT_MS * CLK_MHZ * 1000;
	localparam int T_OVP_REARM_MS = 160;
	localparam int OVP_REARM_CYC  = T_OVP_REARM_MS * CLK_MHZ * 1000;
	localparam int T_SENSE_NS     = 4000;
	localparam int SENSE_CYC      = (T_SENSE_NS * CLK_MHZ + 999) / 1000;

	// ==========================================================
	// Boost target code
	localparam int         CODE_W    = 8;
	localparam logic [7:0] TGT_MIN   = 8'h00;
	localparam logic [7:0] TGT_MAX   = 8'hFF;
	localparam logic [7:0] TGT_INIT  = 8'hE0;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0]  REG_ADAPT  = 8'h00;
	localparam logic [7:0]  REG_DOWN   = 8'h04;
	localparam logic [7:0]  REG_STATUS = 8'h08;
	localparam logic [7:0]  REG_TARGET = 8'h0C;
	localparam logic [15:0] ADAPT_RST  = 16'h00FA;
	localparam logic [15:0] DOWN_RST   = 16'h0010;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_OPEN_LSB  = 2;
	localparam int ST_SHORT_LSB = 5;
	localparam int ST_GND_LSB   = 8;
	localparam int ST_FAULT_BIT = 11;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Device states
	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_SENSE,
		ST_ACTIVE,
		ST_RECOVERY
	} lsf_state_t;
endpackage

// [tb/lsf_host.sv]
/*
 * Host model: drives enable and brightness PWM, reads the fault pin.
 * Assumes aclk at 250 MHz and a pull-up on the open-drain fault pin.
 */
`timescale 1ns/1ps
`default_nettype none
module lsf_host #(
	parameter int HALF = 6250
) (
	input  wire logic aclk,
	input  wire logic en_req,
	input  wire logic fault_o,
	input  wire logic fault_oe,
	output var logic  supply_enable_pin,
	output var logic  pwm_in,
	output wire logic fault_pin
);
	int   cnt    = 0;
	logic en_ff  = 1'b0;
	logic pwm_ff = 1'b0;
	// ==========================================================
	// Pins
	// 20 kHz square wave, top of the allowed band keeps the run short
	always @(posedge aclk) begin
		en_ff <= en_req;
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			pwm_ff <= !pwm_ff;
		end
	end
	assign supply_enable_pin = en_ff;
	assign pwm_in            = pwm_ff;
	// Pull-up wins unless the device sinks the pin
	assign fault_pin = fault_oe ? fault_o : 1'b1;
endmodule
`default_nettype wire

// [tb/lsf_ctrl_tb.sv]
/*
 * Self-checking bench of the sink fault and adaptive boost controller.
 * Assumes shortened timing parameters; the host model drives the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module lsf_ctrl_tb;
	import lsf_pkg::*;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0;
	logic        arv = 0, rready = 0, vov = 0, vun = 0, oov = 0;
	logic        hot = 0, en_req = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [2:0]  gnd = 0, flo = 0, ceil = 0, shrt = 0, sink_en;
	logic        awrdy, wrdy, bv, arrdy, rv, boost_en, fault_o, fault_oe;
	logic        en_pin, pwm, fpin, p;
	logic [1:0]  bresp, rresp, r;
	logic [7:0]  tgt, t0;
	int          num_errors = 0, n_checks = 0;

	// ==========================================================
	// Design and host
	lsf_ctrl #(.CLR_MAX(600), .PERSIST(50), .RECOV(200), .OVP_LONG(300),
		.OVP_SHORT(100), .OVP_REARM(400)) lsf_ctrl_i (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
		.supply_enable_pin(en_pin), .pwm_in(pwm), .sink_grounded(gnd),
		.cmp_floor_below(flo), .cmp_ceiling_above(ceil),
		.cmp_short_above(shrt), .vin_over_raw(vov), .vin_under_raw(vun),
		.vout_over_raw(oov), .die_hot(hot), .sink_en(sink_en),
		.boost_en(boost_en), .boost_target(tgt), .fault_o(fault_o),
		.fault_oe(fault_oe));
	lsf_host lsf_host_i (.aclk(aclk), .en_req(en_req), .fault_o(fault_o),
		.fault_oe(fault_oe), .supply_enable_pin(en_pin), .pwm_in(pwm),
		.fault_pin(fpin));

	// ==========================================================
	// Helpers
	initial forever #2 aclk = ~aclk;
	task conclude;
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge aclk);
	endtask
	// Sample at the falling edge, act right after the rising edge
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awv & awrdy;
			tw = wv & wrdy;
			tb = bv;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arv & arrdy;
			tr = rv;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arv <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask
	task setc(input logic [2:0] f, input logic [2:0] c);
		@(posedge aclk);
		flo <= f;
		ceil <= c;
	endtask

	// ==========================================================
	// Scenarios
	task t_start;
		rd(REG_STATUS);
		chk(d, 0);
		rd(8'h10);
		chk(r, RESP_SLVERR);
		gnd <= 3'b100;
		en_req <= 1'b1;
		cyc(1100);
		rd(REG_STATUS);
		chk(d[1:0], 2);
		chk(d[10:8], 3'b100);
	endtask
	// Grounded sink stays dark while the others follow the PWM
	task t_pwm;
		cyc(1);
		p = pwm;
		repeat (25000) begin
			cyc(1);
			chk(sink_en, {1'b0, p, p});
			p = pwm;
		end
	endtask
	task t_adapt;
		wr(REG_ADAPT, 4);
		wr(REG_DOWN, 32'hFFFF);
		cyc(300);
		t0 = tgt;
		cyc(300);
		chk(tgt, t0);
		setc(0, 3'b011);
		cyc(600);
		chk(tgt < t0, 1);
		setc(0, 0);
		cyc(300);
		wr(REG_DOWN, 2);
		cyc(1);
		t0 = tgt;
		cyc(100);
		chk(tgt < t0, 1);
		wr(REG_DOWN, 32'hFFFF);
		setc(3'b001, 0);
		for (int i = 0; i < 3000 && !fault_oe; i++) cyc(1);
		chk(tgt, TGT_MAX);
		chk(fpin, 0);
		rd(REG_STATUS);
		chk(d[4:0], 5'b00110);
		while (!pwm) cyc(1);
		cyc(1);
		chk(sink_en, 3'b010);
	endtask
	// Short low pulse inside the window clears the string faults and stays active
	task t_clear;
		setc(0, 0);
		en_req <= 1'b0;
		cyc(250);
		chk(sink_en, 0);
		cyc(270);
		en_req <= 1'b1;
		cyc(10);
		chk(fpin, 1);
		rd(REG_STATUS);
		chk(d[7:0], 8'h02);
	endtask
	// Short on sink 1 while sink 0 stays a healthy reference
	task t_short;
		@(posedge aclk);
		shrt <= 3'b010;
		for (int i = 0; i < 400 && !fault_oe; i++) cyc(1);
		chk(fpin, 0);
		rd(REG_STATUS);
		chk(d[11:0], 12'hC42);
		while (!pwm) cyc(1);
		cyc(1);
		chk(sink_en, 3'b001);
		@(posedge aclk);
		shrt <= 3'b000;
		t_clear;
	endtask
	// Mode 0 overtemperature, 1 undervoltage, 2 input overvoltage
	task t_recov(input logic [1:0] k);
		@(posedge aclk);
		hot <= k == 2'h0;
		vun <= k == 2'h1;
		vov <= k == 2'h2;
		cyc(30);
		chk(boost_en, k != 2'h0);
		for (int i = 0; i < 400 && boost_en; i++) cyc(1);
		cyc(1);
		chk({fpin, sink_en}, 0);
		cyc(450);
		chk({boost_en, fpin}, 0);
		@(posedge aclk);
		hot <= 1'b0;
		vun <= 1'b0;
		vov <= 1'b0;
		for (int i = 0; i < 600 && !boost_en; i++) cyc(1);
		chk({boost_en, fpin}, 2'b11);
	endtask
	// Output overvoltage: long filter, short after a trip, then rearmed
	task t_ovp;
		@(posedge aclk);
		oov <= 1'b1;
		cyc(250);
		chk(boost_en, 1);
		for (int i = 0; i < 200 && boost_en; i++) cyc(1);
		for (int i = 0; i < 600 && !boost_en; i++) cyc(1);
		cyc(150);
		chk(boost_en, 0);
		@(posedge aclk);
		oov <= 1'b0;
		for (int i = 0; i < 600 && !boost_en; i++) cyc(1);
		cyc(450);
		@(posedge aclk);
		oov <= 1'b1;
		cyc(250);
		chk(boost_en, 1);
		for (int i = 0; i < 200 && boost_en; i++) cyc(1);
		chk(fpin, 0);
		@(posedge aclk);
		oov <= 1'b0;
		for (int i = 0; i < 600 && !boost_en; i++) cyc(1);
		chk(fpin, 1);
	endtask
	task t_standby;
		en_req <= 1'b0;
		cyc(800);
		rd(REG_STATUS);
		chk({boost_en, d[1:0]}, 0);
		en_req <= 1'b1;
		cyc(5);
		rd(REG_STATUS);
		chk({boost_en, d[1:0]}, 3'b101);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_start;
		t_pwm;
		t_adapt;
		t_clear;
		t_short;
		t_recov(2'h0);
		t_recov(2'h1);
		t_recov(2'h2);
		t_ovp;
		t_standby;
		conclude;
	end
	// Whole run needs at most about 52k cycles; allow 75k
	initial begin
		#300000;
		num_errors++;
		conclude;
	end
endmodule
`default_nettype wire
